// ==== pgood_defs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef PGOOD_DEFS_SVH
`define PGOOD_DEFS_SVH
`define CLK_MHZ          40
`define UV_FILTER_NS     10000
`define UV_FILTER_CYC    ((`UV_FILTER_NS * `CLK_MHZ) / 1000)
`define OFF_CTRL         8'h00
`define OFF_STATUS       8'h04
`define OFF_IRQ_STAT     8'h08
`define OFF_IRQ_MASK     8'h0C
`define CTRL_RST_FORCE   3
`define CTRL_RESET       32'h0000_0000
`define MASK_RESET       32'h0000_0000
`define ST_PGOOD         0
`define ST_LOCAL_RST     1
`define ST_BP_RST        2
`define ST_CLASS_A       3
`define ST_CLASS_B       4
`define ST_UV_LSB        8
`define IRQ_PG_LOST      0
`define IRQ_PG_GAINED    1
`define IRQ_CLASS_CHG    2
`define IRQ_BITS         3
`endif

// ==== pgood_pkg.sv ====
// types shared by the supervisory logic
package pgood_pkg;
   typedef logic [1:0] resp_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } rd_state_t;
endpackage

// ==== uv_filter.sv ====
// per-supply undervoltage qualification counter
`timescale 1ns/100ps
`include "pgood_defs.svh"
module uv_filter #(
   parameter int CYCLES = `UV_FILTER_CYC
) (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // synchronised comparator, high when below threshold
   input  wire logic below_i,
   // qualified undervoltage
   output logic      uv_o
);
   localparam int CW = $clog2(CYCLES + 1);
   // a zero dwell would make every glitch a power loss
   if (CYCLES < 1) begin : g_cycles_chk
      $error("uv_filter: CYCLES must be at least 1");
   end
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          uv_r;
   logic          uv_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      uv_nxt  = uv_r;
      if (!below_i) begin
         cnt_nxt = '0;
         uv_nxt  = 1'b0;
      end else if (cnt_r >= CW'(CYCLES)) begin
         uv_nxt  = 1'b1;
      end else begin
         cnt_nxt = cnt_r + CW'(1);
      end
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         uv_r  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         uv_r  <= uv_nxt;
      end
   end
   assign uv_o = uv_r;
   a_uv_needs_dwell: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(uv_r) |-> $past(below_i)) else $error("uv rose without undervoltage");
   a_uv_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
      !below_i |=> !uv_r) else $error("uv not cleared in tolerance");
endmodule

// ==== power_good_reset_logic.sv ====
// power-good, local reset, bus enable and power-class reporting with axi4-lite registers
// Contract
// - supply low over 10 us drops good, resets
// - undervoltage never sets fault or breaker
// - local reset combines only three inputs
// - reset low on backplane, not good, force
// - bus enable holds precharge until good
// - sample class pins, readable by host
`timescale 1ns/100ps
`include "pgood_defs.svh"
module power_good_reset_logic
   import pgood_pkg::*;
#(
   parameter int NSUP      = 4,
   parameter int UV_CYCLES = `UV_FILTER_CYC
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // supply comparators, high when below threshold
   input  wire logic [NSUP-1:0]  supply_below_i,
   // backplane and class pins
   input  wire logic             backplane_reset_pin_i,
   input  wire logic             power_class_pin_a_i,
   input  wire logic             power_class_pin_b_i,
   // open-drain power good, oe low while pulling low
   output logic                  power_good_out_n_o,
   output logic                  power_good_out_n_oe_n_o,
   // local reset, bus enable, interrupt
   output logic                  local_reset_pin_o,
   output logic                  bus_enable_n_o,
   output logic                  irq_o,
   // axi4-lite write address and data
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   // axi4-lite write response
   output pgood_pkg::resp_t      s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output pgood_pkg::resp_t      s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready
);
   import pgood_pkg::*;
   // status word reserves one byte for the per-supply flags
   if (NSUP < 1 || NSUP > 8) begin : g_nsup_chk
      $error("NSUP must be 1..8");
   end
   // two-flop synchronisers for every pin input
   localparam int NIN = NSUP + 3;
   logic [NIN-1:0] meta_r;
   logic [NIN-1:0] sync_r;
   logic [NIN-1:0] pins;
   assign pins = {power_class_pin_b_i, power_class_pin_a_i, backplane_reset_pin_i,
                  supply_below_i};
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins;
         sync_r <= meta_r;
      end
   end
   logic [NSUP-1:0] below_s;
   logic            bp_rst_s;
   logic [1:0]      class_s;
   assign below_s  = sync_r[NSUP-1:0];
   assign bp_rst_s = sync_r[NSUP];
   assign class_s  = sync_r[NSUP+2:NSUP+1];
   // per-supply filters
   logic [NSUP-1:0] uv;
   for (genvar g = 0; g < NSUP; g++) begin : g_filt
      uv_filter #(.CYCLES(UV_CYCLES)) u_filt (
         .mclk_i  (mclk_i),
         .rst_i   (rst_i),
         .below_i (below_s[g]),
         .uv_o    (uv[g])
      );
   end
   // power good drives good, reset and bus enable outputs, no fault path exists
   logic pgood;
   assign pgood = ~|uv;
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic        force_rst;
   assign force_rst = ctrl_r[`CTRL_RST_FORCE];
   // combinational reset, only three terms
   assign local_reset_pin_o = bp_rst_s & pgood & ~force_rst;
   assign power_good_out_n_o      = 1'b0;
   // active-low good pin: pulled low only while every supply is good
   assign power_good_out_n_oe_n_o = ~pgood;
   assign bus_enable_n_o          = ~pgood;
   // interrupt events
   logic pgood_d_r;
   logic [1:0] class_d_r;
   logic [`IRQ_BITS-1:0] ev;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pgood_d_r <= 1'b1;
         class_d_r <= 2'h0;
      end else begin
         pgood_d_r <= pgood;
         class_d_r <= class_s;
      end
   end
   always_comb begin
      ev = '0;
      ev[`IRQ_PG_LOST]   = pgood_d_r & ~pgood;
      ev[`IRQ_PG_GAINED] = ~pgood_d_r & pgood;
      ev[`IRQ_CLASS_CHG] = class_d_r != class_s;
   end
   // axi write path: address and data latched independently
   logic       aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, bvalid_r, bvalid_nxt;
   logic [7:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   resp_t      bresp_r, bresp_nxt;
   logic [`IRQ_BITS-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
   logic       do_wr;
   logic [31:0] wmask;
   localparam logic [31:0] MASK_RST = `MASK_RESET;
   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready  = ~w_have_r & ~bvalid_r;
   assign do_wr = aw_have_r & w_have_r & ~bvalid_r;
   always_comb begin
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      ctrl_nxt    = ctrl_r;
      imask_nxt   = imask_r;
      ist_nxt     = ist_r;
      wmask       = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
      end
      if (do_wr) begin
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = 2'b00;
         if (awaddr_r == `OFF_CTRL) begin
            ctrl_nxt = (ctrl_r & ~wmask) | (wdata_r & wmask);
         end else if (awaddr_r == `OFF_IRQ_MASK) begin
            imask_nxt = (imask_r & ~wmask[`IRQ_BITS-1:0]) | (wdata_r[`IRQ_BITS-1:0]
                        & wmask[`IRQ_BITS-1:0]);
         end else if (awaddr_r == `OFF_IRQ_STAT) begin
            ist_nxt = ist_r & ~(wdata_r[`IRQ_BITS-1:0] & wmask[`IRQ_BITS-1:0]);
         end else if (awaddr_r != `OFF_STATUS) begin
            bresp_nxt = 2'b10;
         end
      end
      // set wins over clear
      ist_nxt = ist_nxt | ev;
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'b00;
         ctrl_r    <= `CTRL_RESET;
         imask_r   <= MASK_RST[`IRQ_BITS-1:0];
         ist_r     <= '0;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         ctrl_r    <= ctrl_nxt;
         imask_r   <= imask_nxt;
         ist_r     <= ist_nxt;
      end
   end
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   assign irq_o = |(ist_r & imask_r);
   // axi read path
   rd_state_t   rst_st_r, rst_st_nxt;
   logic [31:0] rdata_r, rdata_nxt, status;
   resp_t       rresp_r, rresp_nxt;
   always_comb begin
      status = '0;
      status[`ST_PGOOD]     = pgood;
      status[`ST_LOCAL_RST] = local_reset_pin_o;
      status[`ST_BP_RST]    = bp_rst_s;
      status[`ST_CLASS_A]   = class_s[0];
      status[`ST_CLASS_B]   = class_s[1];
      status[`ST_UV_LSB +: NSUP] = uv;
   end
   assign s_axi_arready = (rst_st_r == RD_IDLE);
   always_comb begin
      rst_st_nxt = rst_st_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      case (rst_st_r)
         RD_IDLE: begin
            if (s_axi_arvalid) begin
               rst_st_nxt = RD_RESP;
               rresp_nxt  = 2'b00;
               if (s_axi_araddr == `OFF_CTRL) begin
                  rdata_nxt = ctrl_r;
               end else if (s_axi_araddr == `OFF_STATUS) begin
                  rdata_nxt = status;
               end else if (s_axi_araddr == `OFF_IRQ_STAT) begin
                  rdata_nxt = {{(32-`IRQ_BITS){1'b0}}, ist_r};
               end else if (s_axi_araddr == `OFF_IRQ_MASK) begin
                  rdata_nxt = {{(32-`IRQ_BITS){1'b0}}, imask_r};
               end else begin
                  rdata_nxt = 32'h0000_0000;
                  rresp_nxt = 2'b10;
               end
            end
         end
         RD_RESP: begin
            if (s_axi_rready) begin
               rst_st_nxt = RD_IDLE;
            end
         end
         default: rst_st_nxt = RD_IDLE;
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rst_st_r <= RD_IDLE;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= 2'b00;
      end else begin
         rst_st_r <= rst_st_nxt;
         rdata_r  <= rdata_nxt;
         rresp_r  <= rresp_nxt;
      end
   end
   assign s_axi_rvalid = (rst_st_r == RD_RESP);
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;
   sequence s_force_write;
      do_wr && awaddr_r == `OFF_CTRL && wstrb_r[0] && wdata_r[`CTRL_RST_FORCE];
   endsequence
   a_reset_force: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_force_write |=> !local_reset_pin_o) else $error("force bit did not reset");
   a_reset_terms: assert property (@(posedge mclk_i) disable iff (rst_i)
      local_reset_pin_o == (bp_rst_s && pgood && !force_rst))
      else $error("local reset mismatch");
   a_bp_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
      !backplane_reset_pin_i [*2] |=> !local_reset_pin_o)
      else $error("backplane reset not followed");
   a_pg_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(|uv) |-> power_good_out_n_oe_n_o && !local_reset_pin_o)
      else $error("power good not dropped");
   a_bus_enable: assert property (@(posedge mclk_i) disable iff (rst_i)
      bus_enable_n_o |-> (|uv)) else $error("bus enable with good power");
   a_class_read: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_STATUS
      |=> s_axi_rvalid && s_axi_rdata[`ST_CLASS_B:`ST_CLASS_A] == $past(class_s))
      else $error("class pins not reported");
   // a mask write in the event cycle may legally hide the event
   a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
      |(ev & imask_r) && !(do_wr && awaddr_r == `OFF_IRQ_MASK) |=> irq_o)
      else $error("irq missing");
endmodule

// ==== board_side.sv ====
// far-side model: backplane reset, board class pins and supply comparators
`timescale 1ns/100ps
module board_side (
   // clock
   input  wire logic       mclk_i,
   // requested board state
   input  wire logic [1:0] class_sel_i,
   input  wire logic       bp_reset_n_i,
   input  wire logic [3:0] sag_i,
   // pins toward the device
   output logic            class_a_o,
   output logic            class_b_o,
   output logic            bp_reset_o,
   output logic [3:0]      below_o
);
   // open pins read high through the pull-up
   always_ff @(posedge mclk_i) begin
      case (class_sel_i)
         2'h0: {class_a_o, class_b_o} <= 2'b11;
         2'h1: {class_a_o, class_b_o} <= 2'b01;
         2'h2: {class_a_o, class_b_o} <= 2'b10;
         default: {class_a_o, class_b_o} <= 2'b00;
      endcase
      bp_reset_o <= bp_reset_n_i;
      below_o    <= sag_i;
   end
endmodule

// ==== power_good_reset_logic_bench.sv ====
// self-checking bench for the supervisory logic
`timescale 1ns/100ps
`include "pgood_defs.svh"
module power_good_reset_logic_bench;
   import pgood_pkg::*;
   localparam int UV = 4;
   logic mclk_i = 1'b0, rst_i = 1'b1, bp_n = 1'b0;
   logic [1:0] class_sel = 2'h0;
   logic [3:0] sag = 4'h0, supply_below_i, s_axi_wstrb = 4'h0;
   logic backplane_reset_pin_i, power_class_pin_a_i, power_class_pin_b_i;
   logic power_good_out_n_oe_n_o, local_reset_pin_o, bus_enable_n_o, irq_o;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, pg_pin;
   resp_t s_axi_bresp, s_axi_rresp, rs;
   int fail_count = 0, checks_done = 0, n;
   always #12.5 mclk_i = ~mclk_i;
   board_side far (.mclk_i, .class_sel_i(class_sel), .bp_reset_n_i(bp_n), .sag_i(sag),
      .class_a_o(power_class_pin_a_i), .class_b_o(power_class_pin_b_i),
      .bp_reset_o(backplane_reset_pin_i), .below_o(supply_below_i));
   power_good_reset_logic #(.NSUP(4), .UV_CYCLES(UV)) dut (.mclk_i, .rst_i,
      .supply_below_i, .backplane_reset_pin_i, .power_class_pin_a_i, .power_class_pin_b_i,
      .power_good_out_n_o(pg_pin), .power_good_out_n_oe_n_o, .local_reset_pin_o, .bus_enable_n_o,
      .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // each channel released only at the edge that takes it
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output resp_t r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge mclk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output resp_t r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge mclk_i);
   endtask
   initial begin
      #(25 * 4000);
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      axr(`OFF_CTRL, rd, rs);
      chk("ctrl", `CTRL_RESET, rd);
      axr(`OFF_IRQ_MASK, rd, rs);
      chk("irq_mask", `MASK_RESET, rd);
      chk("local_reset", 0, local_reset_pin_o);
      bp_n <= 1'b1;
      repeat (6) @(posedge mclk_i);
      chk("local_reset", 1, local_reset_pin_o);
      chk("bus_enable_n", 0, bus_enable_n_o);
      chk("pg_oe_n", 0, power_good_out_n_oe_n_o);
      chk("pg_pin", 0, pg_pin);
      axw(`OFF_CTRL, 32'h1 << `CTRL_RST_FORCE, rs);
      chk("bresp", 0, rs);
      chk("local_reset", 0, local_reset_pin_o);
      axr(`OFF_STATUS, rd, rs);
      chk("status", 32'h1D, rd);
      axw(`OFF_CTRL, 32'h0, rs);
      bp_n <= 1'b0;
      repeat (6) @(posedge mclk_i);
      chk("local_reset", 0, local_reset_pin_o);
      bp_n <= 1'b1;
      axw(`OFF_IRQ_STAT, 32'h7, rs);
      // short dips must restart the count, never add up
      repeat (2) begin
         sag <= 4'h1;
         repeat (UV - 1) @(posedge mclk_i);
         sag <= 4'h0;
         @(posedge mclk_i);
      end
      repeat (6) @(posedge mclk_i);
      chk("local_reset", 1, local_reset_pin_o);
      axr(`OFF_IRQ_STAT, rd, rs);
      chk("irq_stat", 32'h0, rd);
      for (int i = 0; i < 4; i++) begin
         sag <= 4'h1 << i;
         n = 0;
         do begin
            @(posedge mclk_i);
            n++;
         end while (local_reset_pin_o !== 1'b0 && n < UV + 10);
         chk("filter_wait", 1, n > UV);
         chk("local_reset", 0, local_reset_pin_o);
         chk("bus_enable_n", 1, bus_enable_n_o);
         chk("pg_oe_n", 1, power_good_out_n_oe_n_o);
         axr(`OFF_STATUS, rd, rs);
         chk("status", 32'h1C | (32'h1 << (`ST_UV_LSB + i)), rd);
         sag <= 4'h0;
         repeat (8) @(posedge mclk_i);
         chk("local_reset", 1, local_reset_pin_o);
      end
      axr(`OFF_IRQ_STAT, rd, rs);
      chk("irq_stat", 32'h3, rd);
      chk("irq", 0, irq_o);
      axw(`OFF_IRQ_MASK, 32'h1, rs);
      chk("irq", 1, irq_o);
      axw(`OFF_IRQ_STAT, 32'h1, rs);
      chk("irq", 0, irq_o);
      axw(`OFF_IRQ_STAT, 32'h7, rs);
      axw(`OFF_IRQ_MASK, 32'h4, rs);
      for (int c = 3; c >= 0; c--) begin
         class_sel <= 2'(c);
         repeat (6) @(posedge mclk_i);
         axr(`OFF_STATUS, rd, rs);
         chk("class_a", (c == 0 || c == 2), rd[`ST_CLASS_A]);
         chk("class_b", (c == 0 || c == 1), rd[`ST_CLASS_B]);
      end
      chk("irq", 1, irq_o);
      // unmapped place answers with an error and no data
      axr(8'h40, rd, rs);
      chk("rresp", 2, rs);
      chk("rdata", 0, rd);
      axw(8'h40, 32'hFFFF_FFFF, rs);
      chk("bresp", 2, rs);
      end_sim();
   end
endmodule
